// File: core/legacy_display_emulation_trap.v
`timescale 1ns/1ps
`include "legacy_emul_defines.vh"

module legacy_display_emulation_trap (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire [9:0]  io_addr,
   input  wire        io_wr,
   input  wire        io_rd,
   input  wire [7:0]  io_wdata,
   output reg  [7:0]  io_rdata_ff,
   output reg         io_rd_valid_ff,
   input  wire        misc_out_bit0,
   input  wire        display_enable,
   input  wire        vsync_active,
   input  wire [19:0] mem_addr,
   output wire        mem_hit_ff,
   output wire [1:0]  mem_bank_ff,
   output wire [15:0] mem_offset_ff,
   output reg         trap_nmi_ff,
   output reg  [15:0] start_address_ff,
   output reg  [15:0] cursor_address_ff,
   output reg  [7:0]  colour_select_ff,
   output reg  [7:0]  mono_mode_ff,
   output reg  [7:0]  colour_mode_ff,
   output reg  [1:0]  mono_config_ff,
   output reg  [7:0]  emulation_control_register_ff
);

   reg  [7:0]  index_ff;
   reg  [7:0]  tag_low_ff;
   reg  [7:0]  tag_high_ff;
   reg  [7:0]  vector_ff [0:3];
   wire [7:0]  crt_rdata [0:`CRT_REG_COUNT-1];

   reg  [7:0]  nxt_tag_low;
   reg  [7:0]  nxt_tag_high;
   reg  [7:0]  nxt_rdata;
   reg  [3:0]  shadow_slot;
   reg         shadow_idx;

   wire [7:0]  shadow_rdata;
   wire        emu_on;
   wire        sel_index;
   wire        sel_data;
   wire        sel_mode;
   wire        sel_status;
   wire        sel_vector;
   wire        native_idx;
   wire        native_only_idx;
   wire        route_native;
   wire        route_shadow;
   wire        shadow_wr;
   wire        native_wr;
   wire        config_live;

   wire        shadow_trap;
   wire        mode_trap;
   wire        config_trap;
   wire        palette_trap;
   wire        native_trap;

   localparam [9:0] VECTOR_BASE = `PORT_VECTOR_BASE;

   assign emu_on       = emulation_control_register_ff[`EMU_ENABLE_BIT];
   assign route_native = emulation_control_register_ff[`EMU_ROUTE_NATIVE];
   assign route_shadow = emulation_control_register_ff[`EMU_ROUTE_SHADOW];

   // Ten-bit decode: the host bus ignores address bits above 9
   assign sel_index  = (io_addr == `PORT_MONO_INDEX) || (io_addr == `PORT_COLOUR_INDEX);
   assign sel_data   = (io_addr == `PORT_MONO_DATA) || (io_addr == `PORT_COLOUR_DATA);
   assign sel_mode   = (io_addr == `PORT_MONO_MODE) || (io_addr == `PORT_COLOUR_MODE);
   assign sel_status = (io_addr == `PORT_MONO_STATUS) || (io_addr == `PORT_COLOUR_STATUS);
   assign sel_vector = (io_addr[9:2] == VECTOR_BASE[9:2]);

   // Indices above the last native register have no storage at all
   assign native_idx      = (index_ff <= {3'b000, `CRT_IDX_LAST});
   assign native_only_idx = native_idx && (index_ff > {3'b000, `CRT_IDX_DIRECT_LAST});

   // Ah and Bh fold onto slots 9 and 10 so the bank stays eleven deep
   always @* begin
      shadow_idx  = 1'b1;
      shadow_slot = index_ff[3:0];
      if (index_ff == `SHADOW_IDX_CUR_ST)
         shadow_slot = 4'h9;
      else if (index_ff == `SHADOW_IDX_CUR_END)
         shadow_slot = 4'hA;
      else if (index_ff > `SHADOW_IDX_LAST_LIN)
         shadow_idx = 1'b0;
   end

   // Emulation off locks the data port onto the native registers
   assign shadow_wr = io_wr && sel_data && emu_on && route_shadow && shadow_idx;
   assign native_wr = io_wr && sel_data && native_idx &&
                      (!emu_on || route_native || !shadow_idx);

   assign config_live = emulation_control_register_ff[`EMU_MONO_GFX] && !misc_out_bit0;

   // Trap sources, each behind the master enable and an enable bit; config shares the mode trap bit
   assign shadow_trap  = shadow_wr &&
                         emulation_control_register_ff[`EMU_SHADOW_TRAP];
   assign mode_trap    = emu_on && io_wr && sel_mode &&
                         emulation_control_register_ff[`EMU_MODE_TRAP];
   assign config_trap  = emu_on && io_wr && (io_addr == `PORT_MONO_CONFIG) &&
                         emulation_control_register_ff[`EMU_MODE_TRAP];
   assign palette_trap = emu_on && io_wr && (io_addr == `PORT_COLOUR_SELECT) &&
                         emulation_control_register_ff[`EMU_PALETTE_TRAP];
   assign native_trap  = emu_on && io_wr && sel_data && native_only_idx &&
                         emulation_control_register_ff[`EMU_NATIVE_TRAP];

   shadow_timing_bank u_shadow (
      .ref_clk (ref_clk),
      .reset   (reset),
      .wr_en   (shadow_wr),
      .slot    (shadow_slot),
      .wdata   (io_wdata),
      .rdata   (shadow_rdata)
   );

   // Window decode is registered, so a hit lags its address by one cycle
   legacy_memory_window u_window (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .mem_addr      (mem_addr),
      .mono_sel      (!misc_out_bit0),
      .colour_gfx    (colour_mode_ff[1]),
      .mono_gfx      (mono_config_ff[0] && mono_mode_ff[1]),
      .mono_full     (mono_config_ff[1]),
      .mem_hit_ff    (mem_hit_ff),
      .mem_bank_ff   (mem_bank_ff),
      .mem_offset_ff (mem_offset_ff)
   );

   // Native timing registers share the legacy index space
   // Every native index keeps storage so the host can save and restore state
   genvar g;
   generate
      for (g = 0; g < `CRT_REG_COUNT; g = g + 1) begin : crt_gen
         reg [7:0] crt_ff;
         always @(posedge ref_clk) begin
            if (reset)
               crt_ff <= `RESET_BYTE;
            else if (native_wr && index_ff == g)
               crt_ff <= io_wdata;
         end
         assign crt_rdata[g] = crt_ff;
      end
   endgenerate

   // Start and cursor addresses leave directly, no host help needed
   always @(posedge ref_clk) begin
      if (reset) begin
         start_address_ff  <= 16'h0000;
         cursor_address_ff <= 16'h0000;
      end else begin
         start_address_ff  <= {crt_rdata[`CRT_IDX_START_HI], crt_rdata[`CRT_IDX_START_LO]};
         cursor_address_ff <= {crt_rdata[`CRT_IDX_CURSOR_HI],
                               crt_rdata[`CRT_IDX_CURSOR_LO]};
      end
   end

   // Plain storage registers
   always @(posedge ref_clk) begin
      if (reset) begin
         index_ff                      <= `RESET_BYTE;
         colour_select_ff              <= `RESET_BYTE;
         mono_mode_ff                  <= `RESET_BYTE;
         colour_mode_ff                <= `RESET_BYTE;
         mono_config_ff                <= 2'b00;
         emulation_control_register_ff <= `EMU_CTRL_RESET;
      end else if (io_wr) begin
         if (sel_index)
            index_ff <= io_wdata;
         if (io_addr == `PORT_COLOUR_SELECT)
            colour_select_ff <= io_wdata;
         if (io_addr == `PORT_MONO_MODE)
            mono_mode_ff <= io_wdata;
         if (io_addr == `PORT_COLOUR_MODE)
            colour_mode_ff <= io_wdata;
         if (io_addr == `PORT_MONO_CONFIG && config_live)
            mono_config_ff <= io_wdata[1:0];
         if (io_addr == `PORT_EMUL_CTRL)
            emulation_control_register_ff <= io_wdata;
      end
   end

   // Scratch bytes for the host's previous interrupt vector
   generate
      for (g = 0; g < 4; g = g + 1) begin : vec_gen
         always @(posedge ref_clk) begin
            if (reset)
               vector_ff[g] <= `RESET_BYTE;
            else if (io_wr && sel_vector && io_addr[1:0] == g)
               vector_ff[g] <= io_wdata;
         end
      end
   endgenerate

   // Tags: host writes ones to clear; a trap in the same cycle wins
   always @* begin
      nxt_tag_low  = tag_low_ff;
      nxt_tag_high = tag_high_ff;
      if (io_wr && io_addr == `PORT_TAG_LOW)
         nxt_tag_low = tag_low_ff & ~io_wdata;
      if (io_wr && io_addr == `PORT_TAG_HIGH)
         nxt_tag_high = tag_high_ff & ~io_wdata;
      if (shadow_trap) begin
         if (shadow_slot < 4'h8)
            nxt_tag_low[shadow_slot[2:0]] = 1'b1;
         else
            nxt_tag_high[shadow_slot[1:0]] = 1'b1;
      end
      if (mode_trap)
         nxt_tag_high[`TAG_HI_MODE] = 1'b1;
      if (config_trap)
         nxt_tag_high[`TAG_HI_CONFIG] = 1'b1;
      if (palette_trap)
         nxt_tag_high[`TAG_HI_PALETTE] = 1'b1;
      if (native_trap)
         nxt_tag_high[`TAG_HI_NATIVE] = 1'b1;
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         tag_low_ff  <= `RESET_BYTE;
         tag_high_ff <= `RESET_BYTE;
         trap_nmi_ff <= 1'b0;
      end else begin
         tag_low_ff  <= nxt_tag_low;
         tag_high_ff <= nxt_tag_high;
         // Level trap: stays up until every tag is cleared, so none is missed
         trap_nmi_ff <= (|nxt_tag_low) || (|nxt_tag_high);
      end
   end

   // Read path
   always @* begin
      nxt_rdata = `RESET_BYTE;
      if (sel_index)
         nxt_rdata = index_ff;
      else if (sel_data) begin
         if (emu_on && route_shadow && !route_native && shadow_idx)
            nxt_rdata = shadow_rdata;
         else if (native_idx)
            nxt_rdata = crt_rdata[index_ff[4:0]];
      end else if (sel_status)
         nxt_rdata = {4'h0, vsync_active, 2'b00, !display_enable};
      else if (io_addr == `PORT_COLOUR_SELECT)
         nxt_rdata = colour_select_ff;
      else if (io_addr == `PORT_MONO_MODE)
         nxt_rdata = mono_mode_ff;
      else if (io_addr == `PORT_COLOUR_MODE)
         nxt_rdata = colour_mode_ff;
      else if (io_addr == `PORT_MONO_CONFIG)
         nxt_rdata = {6'h00, mono_config_ff};
      else if (io_addr == `PORT_EMUL_CTRL)
         nxt_rdata = emulation_control_register_ff;
      else if (io_addr == `PORT_TAG_LOW)
         nxt_rdata = tag_low_ff;
      else if (io_addr == `PORT_TAG_HIGH)
         nxt_rdata = tag_high_ff;
      else if (sel_vector)
         nxt_rdata = vector_ff[io_addr[1:0]];
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         io_rdata_ff    <= `RESET_BYTE;
         io_rd_valid_ff <= 1'b0;
      end else begin
         io_rd_valid_ff <= io_rd;
         // Data stands until the next read, so a slow host can still take it
         if (io_rd)
            io_rdata_ff <= nxt_rdata;
      end
   end

endmodule // legacy_display_emulation_trap

// File: core/legacy_memory_window.v
`timescale 1ns/1ps
`include "legacy_emul_defines.vh"

module legacy_memory_window (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire [19:0] mem_addr,
   input  wire        mono_sel,
   input  wire        colour_gfx,
   input  wire        mono_gfx,
   input  wire        mono_full,
   output reg         mem_hit_ff,
   output reg  [1:0]  mem_bank_ff,
   output reg  [15:0] mem_offset_ff
);

   reg        nxt_hit;
   reg [1:0]  nxt_bank;
   reg [15:0] nxt_offset;

   always @* begin
      nxt_hit    = 1'b0;
      nxt_bank   = 2'b00;
      nxt_offset = 16'h0000;
      if (!mono_sel) begin
         // 16 KB at B8000h, two scan banks in graphics
         nxt_hit    = (mem_addr[19:14] == `WIN_COLOUR_BASE);
         nxt_bank   = colour_gfx ? {1'b0, mem_addr[13]} : 2'b00;
         nxt_offset = {2'b00, mem_addr[13:0]};
      end else if (mono_gfx) begin
         // 32 KB half or 64 KB full at B0000h, four scan banks
         nxt_hit    = (mem_addr[19:15] == `WIN_MONO_BASE) ||
                      (mono_full && mem_addr[19:16] == 4'hB);
         nxt_bank   = mem_addr[14:13];
         nxt_offset = mem_addr[15:0];
      end else begin
         // Text: 4 KB at B0000h
         nxt_hit    = (mem_addr[19:12] == 8'hB0);
         nxt_offset = {4'h0, mem_addr[11:0]};
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         mem_hit_ff    <= 1'b0;
         mem_bank_ff   <= 2'b00;
         mem_offset_ff <= 16'h0000;
      end else begin
         mem_hit_ff    <= nxt_hit;
         mem_bank_ff   <= nxt_bank;
         mem_offset_ff <= nxt_offset;
      end
   end

endmodule // legacy_memory_window

// File: core/shadow_timing_bank.v
`timescale 1ns/1ps
`include "legacy_emul_defines.vh"

module shadow_timing_bank (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        wr_en,
   input  wire [3:0]  slot,
   input  wire [7:0]  wdata,
   output wire [7:0]  rdata
);

   localparam [87:0] MASKS = `SHADOW_MASKS;

   wire [87:0] bank_flat;

   genvar g;
   generate
      for (g = 0; g < `SHADOW_COUNT; g = g + 1) begin : slot_gen
         reg [7:0] value_ff;
         // Unstored bits never latch, so they read back as zero
         always @(posedge ref_clk) begin
            if (reset)
               value_ff <= `RESET_BYTE;
            else if (wr_en && slot == g)
               value_ff <= wdata & MASKS[g*8 +: 8];
         end
         assign bank_flat[g*8 +: 8] = value_ff;
      end
   endgenerate

   assign rdata = (slot < `SHADOW_COUNT) ? bank_flat[slot*8 +: 8] : `RESET_BYTE;

endmodule // shadow_timing_bank

// File: include/legacy_emul_defines.vh
`ifndef LEGACY_EMUL_DEFINES_VH
`define LEGACY_EMUL_DEFINES_VH

// Host I/O ports, 10-bit decode
`define PORT_MONO_INDEX     10'h3B4
`define PORT_MONO_DATA      10'h3B5
`define PORT_MONO_MODE      10'h3B8
`define PORT_MONO_STATUS    10'h3BA
`define PORT_MONO_CONFIG    10'h3BF
`define PORT_COLOUR_INDEX   10'h3D4
`define PORT_COLOUR_DATA    10'h3D5
`define PORT_COLOUR_MODE    10'h3D8
`define PORT_COLOUR_SELECT  10'h3D9
`define PORT_COLOUR_STATUS  10'h3DA
`define PORT_EMUL_CTRL      10'h3DC
`define PORT_TAG_LOW        10'h3DD
`define PORT_TAG_HIGH       10'h3DE
`define PORT_VECTOR_BASE    10'h3E0

// Emulation control register fields
`define EMU_ENABLE_BIT      0
`define EMU_ROUTE_NATIVE    1
`define EMU_MONO_GFX        2
`define EMU_ROUTE_SHADOW    3
`define EMU_SHADOW_TRAP     4
`define EMU_MODE_TRAP       5
`define EMU_PALETTE_TRAP    6
`define EMU_NATIVE_TRAP     7
`define EMU_CTRL_RESET      8'h00

// High tag register fields
`define TAG_HI_MODE         3
`define TAG_HI_CONFIG       4
`define TAG_HI_PALETTE      5
`define TAG_HI_NATIVE       6

// Native timing register indices
`define CRT_REG_COUNT       25
`define CRT_IDX_START_HI    5'h0C
`define CRT_IDX_START_LO    5'h0D
`define CRT_IDX_CURSOR_HI   5'h0E
`define CRT_IDX_CURSOR_LO   5'h0F
`define CRT_IDX_DIRECT_LAST 5'h11
`define CRT_IDX_LAST        5'h18

// Shadow bank: slot count, index map and stored-bit masks (slot 10 in top byte)
`define SHADOW_COUNT        11
`define SHADOW_IDX_CUR_ST   8'h0A
`define SHADOW_IDX_CUR_END  8'h0B
`define SHADOW_IDX_LAST_LIN 8'h08
`define SHADOW_MASKS        88'h1F_7F_33_7F_7F_1F_7F_FF_1F_7F_7F

// Memory windows
`define WIN_MONO_BASE       5'h16
`define WIN_COLOUR_BASE     6'h2E
`define RESET_BYTE          8'h00

`endif

// File: tb/host_model.sv
`timescale 1ns/1ps
`include "legacy_emul_defines.vh"

module host_model (
   input  logic       ref_clk,
   output logic [9:0] io_addr,
   output logic       io_wr,
   output logic       io_rd,
   output logic [7:0] io_wdata,
   input  logic [7:0] io_rdata_ff,
   input  logic       io_rd_valid_ff
);
   logic foreign;

   initial begin
      io_addr = 10'h000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      foreign = 1'b0;
   end

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge ref_clk);
      io_wr = 1'b0;
      // Released data never shows the last value
      io_wdata = ~d;
   endtask

   // A missing answer reads as unknown so no compare can pass on it
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge ref_clk);
      io_rd = 1'b0;
      d = (io_rd_valid_ff === 1'b1) ? io_rdata_ff : 8'hXX;
   endtask

   task automatic service(output logic [15:0] tags);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(`PORT_TAG_LOW, lo);
      rd(`PORT_TAG_HIGH, hi);
      tags = {hi, lo};
      foreign = (tags == 16'h0000);
      wr(`PORT_TAG_LOW, 8'hFF);
      wr(`PORT_TAG_HIGH, 8'hFF);
      @(negedge ref_clk);
   endtask

   // Conversion is software policy; a plain copy stands in for it here
   task automatic translate(input logic [7:0] idx, input logic [7:0] ctl);
      logic [7:0] v;
      wr(`PORT_COLOUR_INDEX, idx);
      rd(`PORT_COLOUR_DATA, v);
      wr(`PORT_EMUL_CTRL, 8'h03);
      wr(`PORT_COLOUR_DATA, v);
      wr(`PORT_EMUL_CTRL, ctl);
   endtask
endmodule // host_model

// File: tb/legacy_display_emulation_trap_tb.sv
`timescale 1ns/1ps
`include "legacy_emul_defines.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end

module legacy_display_emulation_trap_tb;
   logic        ref_clk;
   logic        reset;
   logic [9:0]  io_addr;
   logic        io_wr;
   logic        io_rd;
   logic [7:0]  io_wdata;
   logic [7:0]  io_rdata_ff;
   logic        io_rd_valid_ff;
   logic        misc_out_bit0;
   logic        display_enable;
   logic        vsync_active;
   logic [19:0] mem_addr;
   logic        mem_hit_ff;
   logic [1:0]  mem_bank_ff;
   logic [15:0] mem_offset_ff;
   logic        trap_nmi_ff;
   logic [15:0] start_address_ff;
   logic [15:0] cursor_address_ff;
   logic [7:0]  colour_select_ff;
   logic [7:0]  mono_mode_ff;
   logic [7:0]  colour_mode_ff;
   logic [1:0]  mono_config_ff;
   logic [7:0]  emulation_control_register_ff;
   int          err_total;
   int          checks_done;
   logic [7:0]  d;
   logic [7:0]  r;
   logic [15:0] t;
   logic [3:0]  s;
   logic [13:0] o;
   logic [7:0]  tc [4] = '{8'h21, 8'h41, 8'h81, 8'h21};
   logic [9:0]  tp [4] = '{`PORT_COLOUR_MODE, `PORT_COLOUR_SELECT, `PORT_COLOUR_DATA,
                          `PORT_MONO_CONFIG};
   logic [15:0] tg [4] = '{16'h0800, 16'h2000, 16'h4000, 16'h1000};

   legacy_display_emulation_trap legacy_display_emulation_trap_i (
      .ref_clk(ref_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .io_rd_valid_ff(io_rd_valid_ff),
      .misc_out_bit0(misc_out_bit0), .display_enable(display_enable),
      .vsync_active(vsync_active), .mem_addr(mem_addr), .mem_hit_ff(mem_hit_ff),
      .mem_bank_ff(mem_bank_ff), .mem_offset_ff(mem_offset_ff), .trap_nmi_ff(trap_nmi_ff),
      .start_address_ff(start_address_ff), .cursor_address_ff(cursor_address_ff),
      .colour_select_ff(colour_select_ff), .mono_mode_ff(mono_mode_ff),
      .colour_mode_ff(colour_mode_ff), .mono_config_ff(mono_config_ff),
      .emulation_control_register_ff(emulation_control_register_ff));

   host_model host_model_i (
      .ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .io_rd_valid_ff(io_rd_valid_ff));

   always #5 ref_clk = ~ref_clk;

   function automatic logic [7:0] mask_of(input logic [3:0] i);
      case (i)
         4'h2, 4'h5, 4'hB: return 8'h1F;
         4'h3: return 8'hFF;
         4'h8: return 8'h33;
         default: return 8'h7F;
      endcase
   endfunction

   // Slots 8, Ah and Bh sit in the high tag byte, Ah skipping the unused 9
   function automatic logic [15:0] tag_of(input logic [3:0] i);
      return (i < 8) ? 16'h0001 << i : 16'h0100 << (i - 8 - (i > 8));
   endfunction

   task automatic wrap_up;
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #300000;
      err_total++;
      wrap_up;
   end

   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      misc_out_bit0 = 1'b1;
      display_enable = 1'b0;
      vsync_active = 1'b0;
      mem_addr = 20'h00000;
      err_total = 0;
      checks_done = 0;
      d = 8'($urandom(32'h4DA2));
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      `CHK({trap_nmi_ff, emulation_control_register_ff}, 9'h000)
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         host_model_i.wr(10'(`PORT_VECTOR_BASE + i), d);
         host_model_i.rd(10'(`PORT_VECTOR_BASE + i), r);
         `CHK(r, d)
      end
      // Emulation off: native pairs are direct, shadow indices stay silent
      for (int i = 12; i < 16; i++) begin
         d = 8'($urandom);
         host_model_i.wr(`PORT_COLOUR_INDEX, 8'(i));
         host_model_i.wr(`PORT_COLOUR_DATA, d);
         // Address outputs follow the native register one cycle later
         @(negedge ref_clk);
         t = (i % 2) ? {t[15:8], d} : {d, t[7:0]};
         if (i == 13) `CHK(start_address_ff, t)
         if (i == 15) `CHK(cursor_address_ff, t)
      end
      host_model_i.wr(`PORT_COLOUR_INDEX, 8'h02);
      host_model_i.wr(`PORT_COLOUR_DATA, 8'hFF);
      `CHK(trap_nmi_ff, 1'b0)
      host_model_i.wr(`PORT_EMUL_CTRL, 8'h19);
      for (int i = 0; i < 12; i++) begin
         s = 4'(i);
         d = (i == 3) ? 8'hFF : 8'($urandom);
         host_model_i.wr(`PORT_COLOUR_INDEX, {4'h0, s});
         host_model_i.wr(`PORT_COLOUR_DATA, d);
         if (i == 9) begin
            host_model_i.service(t);
            `CHK(t, 16'h0000)
            `CHK(host_model_i.foreign, 1'b1)
         end else begin
            `CHK(trap_nmi_ff, 1'b1)
            host_model_i.service(t);
            `CHK(t, tag_of(s))
            `CHK(host_model_i.foreign, 1'b0)
            `CHK(trap_nmi_ff, 1'b0)
            host_model_i.rd(`PORT_COLOUR_DATA, r);
            `CHK(r, d & mask_of(s))
         end
      end
      host_model_i.wr(`PORT_EMUL_CTRL, 8'h09);
      host_model_i.wr(`PORT_COLOUR_INDEX, 8'h00);
      host_model_i.wr(`PORT_COLOUR_DATA, 8'h55);
      `CHK(trap_nmi_ff, 1'b0)
      host_model_i.translate(8'h00, 8'h09);
      host_model_i.wr(`PORT_EMUL_CTRL, 8'h00);
      host_model_i.rd(`PORT_COLOUR_DATA, r);
      `CHK(r, 8'h55)
      // Both routes at once: native and shadow copies take the same write
      host_model_i.wr(`PORT_EMUL_CTRL, 8'h0B);
      host_model_i.wr(`PORT_COLOUR_DATA, 8'hC6);
      host_model_i.rd(`PORT_COLOUR_DATA, r);
      `CHK(r, 8'hC6)
      host_model_i.wr(`PORT_EMUL_CTRL, 8'h09);
      host_model_i.rd(`PORT_COLOUR_DATA, r);
      `CHK(r, 8'h46)
      for (int i = 0; i < 4; i++) begin
         host_model_i.wr(`PORT_EMUL_CTRL, tc[i]);
         host_model_i.wr(`PORT_COLOUR_INDEX, 8'h12);
         host_model_i.wr(tp[i], 8'h00);
         `CHK(trap_nmi_ff, 1'b1)
         host_model_i.service(t);
         `CHK(t, tg[i])
      end
      host_model_i.wr(`PORT_EMUL_CTRL, 8'h04);
      misc_out_bit0 = 1'b0;
      host_model_i.wr(`PORT_MONO_CONFIG, 8'h03);
      `CHK(mono_config_ff, 2'h3)
      misc_out_bit0 = 1'b1;
      host_model_i.wr(`PORT_MONO_CONFIG, 8'h00);
      `CHK(mono_config_ff, 2'h3)
      host_model_i.wr(`PORT_COLOUR_MODE, 8'h02);
      `CHK(colour_mode_ff, 8'h02)
      // Random offsets in both windows, one step past the 4K text window too
      for (int i = 0; i < 40; i++) begin
         misc_out_bit0 = 1'(i % 2);
         display_enable = 1'($urandom);
         vsync_active = 1'($urandom);
         o = 14'($urandom);
         mem_addr = misc_out_bit0 ? {6'h2E, o} : {8'hB0, o[11:0]};
         @(negedge ref_clk);
         `CHK(mem_hit_ff, 1'b1)
         `CHK(mem_offset_ff, misc_out_bit0 ? {2'h0, o} : {4'h0, o[11:0]})
         `CHK(mem_bank_ff, misc_out_bit0 ? {1'b0, o[13]} : 2'b00)
         mem_addr = {8'hB1, o[11:0]};
         @(negedge ref_clk);
         `CHK(mem_hit_ff, 1'b0)
         host_model_i.rd(misc_out_bit0 ? `PORT_COLOUR_STATUS : `PORT_MONO_STATUS, r);
         `CHK({r[3], r[0]}, {vsync_active, ~display_enable})
      end
      // Monochrome graphics over the full 64K, four scan banks
      host_model_i.wr(`PORT_MONO_MODE, 8'h02);
      `CHK(mono_mode_ff, 8'h02)
      misc_out_bit0 = 1'b0;
      mem_addr = {6'h2F, o};
      @(negedge ref_clk);
      `CHK({mem_hit_ff, mem_bank_ff, mem_offset_ff}, {1'b1, 1'b1, o[13], 2'b11, o})
      wrap_up;
   end
endmodule // legacy_display_emulation_trap_tb

// File: tb/legacy_emul_props.sv
`timescale 1ns/1ps
`include "legacy_emul_defines.vh"

module legacy_emul_props (
   input logic        ref_clk,
   input logic        reset,
   input logic [9:0]  io_addr,
   input logic        io_wr,
   input logic        io_rd,
   input logic [7:0]  io_wdata,
   input logic        io_rd_valid_ff,
   input logic        misc_out_bit0,
   input logic [19:0] mem_addr,
   input logic        mem_hit_ff,
   input logic        trap_nmi_ff,
   input logic [15:0] start_address_ff,
   input logic [15:0] cursor_address_ff,
   input logic [7:0]  colour_select_ff,
   input logic [1:0]  mono_config_ff,
   input logic [7:0]  emulation_control_register_ff
);
   logic [7:0] idx_ff;
   wire        dwr = io_wr && io_addr == `PORT_COLOUR_DATA;
   wire [7:0]  ctl = emulation_control_register_ff;
   wire        ixw = io_addr == `PORT_COLOUR_INDEX || io_addr == `PORT_MONO_INDEX;

   // Mirror of the index so data-port checks know their target
   always @(posedge ref_clk) begin
      if (reset)
         idx_ff <= 8'h00;
      else if (io_wr && ixw)
         idx_ff <= io_wdata;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_shadow_wr;
      dwr && ctl[0] && ctl[3] && (idx_ff <= 8'h08 || idx_ff == 8'h0A || idx_ff == 8'h0B);
   endsequence

   AST_RD_VALID: assert property (io_rd |=> io_rd_valid_ff)
      else $error("read answer missing");
   AST_RD_QUIET: assert property (!io_rd |=> !io_rd_valid_ff)
      else $error("read answer without read");
   AST_SHADOW_TRAP: assert property (s_shadow_wr ##0 ctl[4] |=> trap_nmi_ff)
      else $error("shadow write did not trap");
   AST_OFF_QUIET: assert property (!ctl[0] && !trap_nmi_ff
      && !(io_wr && io_addr == `PORT_EMUL_CTRL) |=> !trap_nmi_ff)
      else $error("trap with emulation off");
   AST_START_HI: assert property (dwr && !ctl[0] && idx_ff == 8'h0C
      |=> ##1 start_address_ff[15:8] == $past(io_wdata, 2))
      else $error("start address high byte wrong");
   AST_CURSOR_LO: assert property (dwr && !ctl[0] && idx_ff == 8'h0F
      |=> ##1 cursor_address_ff[7:0] == $past(io_wdata, 2))
      else $error("cursor low byte wrong");
   AST_CTRL_WR: assert property (io_wr && io_addr == `PORT_EMUL_CTRL
      |=> ctl == $past(io_wdata))
      else $error("control register not written");
   AST_SELECT_WR: assert property (io_wr && io_addr == `PORT_COLOUR_SELECT
      |=> colour_select_ff == $past(io_wdata))
      else $error("colour select not written");
   AST_CFG_HOLD: assert property (io_wr && io_addr == `PORT_MONO_CONFIG
      && !(ctl[2] && !misc_out_bit0) |=> $stable(mono_config_ff))
      else $error("config changed while locked");
   AST_COLOUR_HIT: assert property (misc_out_bit0 && mem_addr[19:14] == 6'h2E
      |=> mem_hit_ff)
      else $error("colour window missed");
endmodule // legacy_emul_props

bind legacy_display_emulation_trap legacy_emul_props props_i (
   .ref_clk(ref_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rd_valid_ff(io_rd_valid_ff), .misc_out_bit0(misc_out_bit0),
   .mem_addr(mem_addr), .mem_hit_ff(mem_hit_ff), .trap_nmi_ff(trap_nmi_ff),
   .start_address_ff(start_address_ff), .cursor_address_ff(cursor_address_ff),
   .colour_select_ff(colour_select_ff), .mono_config_ff(mono_config_ff),
   .emulation_control_register_ff(emulation_control_register_ff));
